/* File: hdl/pld_array_core.sv */
/*
 * Programmable AND/OR array core with its macrocells, signature,
 * copy-protection cell, preload/diagnostics and power-up reset;
 * configuration is programmed over an APB slave port.
 * Assumes all pins synchronous to pclk; the I/O pin level is
 * resolved outside from io_out and io_oe.
 */
`timescale 1ns/100ps
module pld_array_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [9:0]  in_pin,
  input  wire logic [9:0]  in_driven,
  input  wire logic [9:0]  io_in,
  input  wire logic [9:0]  io_driven,
  output logic      [9:0]  io_out,
  output logic      [9:0]  io_oe,
  input  wire logic        input_clock,
  input  wire logic        output_clock
);

  // ---------------------------------------------------------------
  // Configuration storage
  // ---------------------------------------------------------------
  logic [31:0]         and_mem [pld_pkg::N_PT][pld_pkg::AND_WORDS];
  logic [31:0]         or_mem  [pld_pkg::N_ST][pld_pkg::OR_WORDS];
  logic [31:0]         sig_mem [pld_pkg::SIG_WORDS];
  pld_pkg::mc_cfg_type mc_mem  [pld_pkg::N_MC];
  pld_pkg::in_mode_type inc_mem [pld_pkg::N_INC];
  logic                secured_r;
  logic                diag_r;
  logic [31:0]         chk_r;
  logic [31:0]         chk_nxt;
  logic [pld_pkg::PL0_W-1:0] preld0_r;
  logic [pld_pkg::POR_CW-1:0] por_cnt_r;
  logic [31:0]         prdata_r;
  logic                pslverr_r;
  logic                input_clock_prev_r;
  logic                output_clock_prev_r;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic       setup;
  logic       wr_en;
  logic       aligned;
  logic [6:0] and_pt;
  logic [5:0] or_st;
  logic [4:0] cell_idx;
  logic [1:0] wd;
  logic hit_ctrl, hit_stat, hit_chk, hit_pl0, hit_pl1, hit_dg0, hit_dg1;
  logic hit_sig, hit_mc, hit_inc, hit_and, hit_or, cfg_hit;

  assign setup    = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign aligned  = (paddr[1:0] == 2'h0);
  assign and_pt   = paddr[10:4];
  assign or_st    = paddr[9:4];
  assign cell_idx = paddr[6:2];
  assign wd       = paddr[3:2];

  assign hit_ctrl = (paddr == pld_pkg::ADDR_CTRL);
  assign hit_stat = (paddr == pld_pkg::ADDR_STATUS);
  assign hit_chk  = (paddr == pld_pkg::ADDR_CHKSUM);
  assign hit_pl0  = (paddr == pld_pkg::ADDR_PRELD0);
  assign hit_pl1  = (paddr == pld_pkg::ADDR_PRELD1);
  assign hit_dg0  = (paddr == pld_pkg::ADDR_DIAG0);
  assign hit_dg1  = (paddr == pld_pkg::ADDR_DIAG1);
  assign hit_sig  = aligned && paddr[15:4] == pld_pkg::ROW_SIG &&
                    wd < pld_pkg::SIG_WORDS;
  assign hit_mc   = aligned && paddr[15:8] == pld_pkg::PAGE_MC &&
                    !paddr[7] && cell_idx < pld_pkg::N_MC;
  assign hit_inc  = aligned && paddr[15:8] == pld_pkg::PAGE_INC &&
                    !paddr[7] && cell_idx < pld_pkg::N_INC;
  assign hit_and  = aligned && paddr[15:12] == pld_pkg::PAGE_AND &&
                    !paddr[11] && and_pt < pld_pkg::N_PT &&
                    wd < pld_pkg::AND_WORDS;
  assign hit_or   = aligned && paddr[15:12] == pld_pkg::PAGE_OR &&
                    paddr[11:10] == 2'h0 && or_st < pld_pkg::N_ST &&
                    wd < pld_pkg::OR_WORDS;
  assign cfg_hit  = hit_sig | hit_mc | hit_inc | hit_and | hit_or;

  // ---------------------------------------------------------------
  // Raw configuration word and write mask
  // ---------------------------------------------------------------
  logic [31:0] cfg_word;
  logic [31:0] wmask;
  logic [31:0] wval;

  always_comb begin
    cfg_word = '0;
    wmask    = '0;
    if (hit_sig) begin
      cfg_word = sig_mem[wd];
      wmask    = (wd == 2'h2) ? pld_pkg::MASK_SIG_TOP : pld_pkg::MASK_FULL;
    end else if (hit_mc) begin
      cfg_word = {28'h0, mc_mem[cell_idx]};
      wmask    = pld_pkg::MASK_MC;
    end else if (hit_inc) begin
      cfg_word = {30'h0, inc_mem[cell_idx]};
      wmask    = pld_pkg::MASK_INC;
    end else if (hit_and) begin
      cfg_word = and_mem[and_pt][wd];
      wmask    = (wd == 2'h2) ? pld_pkg::MASK_AND_TOP : pld_pkg::MASK_FULL;
    end else if (hit_or) begin
      cfg_word = or_mem[or_st][wd[0]];
      wmask    = pld_pkg::MASK_FULL;
    end
  end

  logic erase;
  logic secure_set;
  logic cfg_wr;
  logic preload;
  logic por_busy;

  assign wval       = pwdata & wmask;
  assign erase      = wr_en & hit_ctrl & pwdata[pld_pkg::CTRL_ERASE];
  assign secure_set = wr_en & hit_ctrl & pwdata[pld_pkg::CTRL_SECURE];
  assign cfg_wr     = wr_en & cfg_hit;
  assign preload    = wr_en & hit_pl1;
  assign por_busy   = (por_cnt_r != pld_pkg::POR_CW'(pld_pkg::POR_CYCLES));

  // Running sum of every stored word, signature included
  assign chk_nxt = erase  ? 32'h0 :
                   cfg_wr ? chk_r + wval - cfg_word : chk_r;

  // ---------------------------------------------------------------
  // Configuration writes; only presetn and bulk erase clear them,
  // never the array reset or the power-up clear
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin : plane_store
    if (!presetn) begin
      for (int p = 0; p < pld_pkg::N_PT; p++)
        for (int w = 0; w < pld_pkg::AND_WORDS; w++)
          and_mem[p][w] <= '0;
      for (int s = 0; s < pld_pkg::N_ST; s++)
        for (int w = 0; w < pld_pkg::OR_WORDS; w++)
          or_mem[s][w] <= '0;
    end else if (erase) begin
      for (int p = 0; p < pld_pkg::N_PT; p++)
        for (int w = 0; w < pld_pkg::AND_WORDS; w++)
          and_mem[p][w] <= '0;
      for (int s = 0; s < pld_pkg::N_ST; s++)
        for (int w = 0; w < pld_pkg::OR_WORDS; w++)
          or_mem[s][w] <= '0;
    end else if (cfg_wr && hit_and) begin
      and_mem[and_pt][wd] <= wval;
    end else if (cfg_wr && hit_or) begin
      or_mem[or_st][wd[0]] <= wval;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin : cell_store
    if (!presetn) begin
      for (int i = 0; i < pld_pkg::N_MC; i++) mc_mem[i] <= '0;
      for (int i = 0; i < pld_pkg::N_INC; i++) inc_mem[i] <= pld_pkg::IN_COMB;
      for (int i = 0; i < pld_pkg::SIG_WORDS; i++) sig_mem[i] <= '0;
    end else if (erase) begin
      for (int i = 0; i < pld_pkg::N_MC; i++) mc_mem[i] <= '0;
      for (int i = 0; i < pld_pkg::N_INC; i++) inc_mem[i] <= pld_pkg::IN_COMB;
      for (int i = 0; i < pld_pkg::SIG_WORDS; i++) sig_mem[i] <= '0;
    end else if (cfg_wr && hit_mc) begin
      mc_mem[cell_idx] <= pld_pkg::mc_cfg_type'(wval[3:0]);
    end else if (cfg_wr && hit_inc) begin
      inc_mem[cell_idx] <= pld_pkg::in_mode_type'(wval[1:0]);
    end else if (cfg_wr && hit_sig) begin
      sig_mem[wd] <= wval;
    end
  end

  // A secure request in the same write as an erase still lands
  always_ff @(posedge pclk or negedge presetn) begin : ctrl_regs
    if (!presetn) begin
      secured_r <= 1'b0;
      diag_r    <= 1'b0;
      chk_r     <= '0;
      preld0_r  <= '0;
    end else begin
      secured_r <= secure_set | (secured_r & ~erase);
      diag_r    <= (wr_en && hit_ctrl) ? pwdata[pld_pkg::CTRL_DIAG] : diag_r;
      chk_r     <= chk_nxt;
      preld0_r  <= (wr_en && hit_pl0) ? pwdata[pld_pkg::PL0_W-1:0]
                                      : preld0_r;
    end
  end

  // ---------------------------------------------------------------
  // Power-up reset and clock edges
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin : por_seq
    if (!presetn) begin
      por_cnt_r   <= '0;
      input_clock_prev_r <= 1'b0;
      output_clock_prev_r <= 1'b0;
    end else begin
      por_cnt_r   <= por_busy ? por_cnt_r + 1'b1 : por_cnt_r;
      input_clock_prev_r <= input_clock;
      output_clock_prev_r <= output_clock;
    end
  end

  logic input_clock_rise;
  logic output_clock_rise;
  assign input_clock_rise = input_clock & ~input_clock_prev_r;
  assign output_clock_rise = output_clock & ~output_clock_prev_r;

  // ---------------------------------------------------------------
  // Cells
  // ---------------------------------------------------------------
  pld_pkg::cell_state_type cur_state;
  logic [pld_pkg::STATE_W-1:0] load_vec;
  logic [pld_pkg::N_INC-1:0] pin_lvl;
  logic [pld_pkg::N_INC-1:0] inc_q;
  logic [pld_pkg::N_MC-1:0]  mc_q;
  logic [pld_pkg::N_MC-1:0]  mc_out;
  logic [pld_pkg::N_PT-1:0]  pt;
  logic [pld_pkg::N_ST-1:0]  st;
  logic [pld_pkg::N_SIG-1:0] sigs;
  logic [pld_pkg::N_LIT-1:0] lit;

  assign pin_lvl  = {io_in | ~io_driven, in_pin | ~in_driven};
  assign load_vec = {pwdata[pld_pkg::STATE_W-pld_pkg::PL0_W-1:0], preld0_r};
  assign cur_state = {mc_q, inc_q};

  generate
    for (genvar i = 0; i < pld_pkg::N_INC; i++) begin : g_inc
      input_cell u_inc (
        .pclk        (pclk),
        .presetn     (presetn),
        .pin         (pin_lvl[i]),
        .clk_level   (input_clock),
        .clk_rise    (input_clock_rise),
        .pwrup_clear (por_busy),
        .load        (preload),
        .load_val    (load_vec[i]),
        .mode        (inc_mem[i]),
        .q           (inc_q[i])
      );
    end
    for (genvar i = 0; i < pld_pkg::N_MC; i++) begin : g_mc
      macrocell #(.HAS_XOR_D(i < pld_pkg::N_OUT)) u_mc (
        .pclk        (pclk),
        .presetn     (presetn),
        .d_term      (st[i]),
        .e_term      (st[pld_pkg::N_MC + i]),
        .output_clock_rise   (output_clock_rise),
        .cfg         (mc_mem[i]),
        .array_rst   (pt[pld_pkg::PT_RESET]),
        .pwrup_clear (por_busy),
        .load        (preload),
        .load_val    (load_vec[pld_pkg::N_INC + i]),
        .q           (mc_q[i]),
        .cell_out    (mc_out[i])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // AND and OR planes
  // ---------------------------------------------------------------
  // Feedback is taken from the cell registers, masked combinationally
  // by the array reset term, so a loop can form through pt[PT_RESET].
  assign sigs = {input_clock, mc_q[pld_pkg::N_MC-1:pld_pkg::N_OUT],
                 mc_q[pld_pkg::N_OUT-1:0], inc_q};

  generate
    for (genvar s = 0; s < pld_pkg::N_SIG; s++) begin : g_lit
      assign lit[2*s]     = sigs[s];
      assign lit[2*s + 1] = ~sigs[s];
    end
    for (genvar p = 0; p < pld_pkg::N_PT; p++) begin : g_pt
      logic [pld_pkg::N_LIT-1:0] conn;
      assign conn = {and_mem[p][2][pld_pkg::AND_TOP_W-1:0],
                     and_mem[p][1], and_mem[p][0]};
      // A term with nothing connected stays inactive
      assign pt[p] = (|conn) & (&(lit | ~conn));
    end
    for (genvar t = 0; t < pld_pkg::N_ST; t++) begin : g_st
      assign st[t] = |({or_mem[t][1], or_mem[t][0]} &
                       pt[pld_pkg::N_OR_IN-1:0]);
    end
  endgenerate

  // Inverting pin buffer: cleared registers drive high
  assign io_out = ~mc_out[pld_pkg::N_OUT-1:0];
  assign io_oe  = pt[pld_pkg::PT_OE +: pld_pkg::N_OUT];

  // ---------------------------------------------------------------
  // APB read path, answered from the setup cycle
  // ---------------------------------------------------------------
  logic [31:0] rd_data;
  logic        rd_err;
  logic        ro_hit;
  logic        any_hit;

  assign ro_hit  = hit_stat | hit_chk | hit_dg0 | hit_dg1;
  assign any_hit = cfg_hit | ro_hit | hit_ctrl | hit_pl0 | hit_pl1;

  always_comb begin
    rd_data = '0;
    rd_err  = !any_hit || (pwrite && ro_hit);
    if (!pwrite) begin
      if (hit_and && secured_r) begin
        rd_err = 1'b1;
      end else if (cfg_hit) begin
        rd_data = cfg_word;
      end else if (hit_ctrl) begin
        rd_data[pld_pkg::CTRL_DIAG] = diag_r;
      end else if (hit_stat) begin
        rd_data = {29'h0, por_busy, diag_r, secured_r};
      end else if (hit_chk) begin
        rd_data = chk_r;
      end else if (hit_pl0) begin
        rd_data = {12'h0, preld0_r};
      end else if ((hit_dg0 || hit_dg1) && !diag_r) begin
        rd_err = 1'b1;
      end else if (hit_dg0) begin
        rd_data = {12'h0, cur_state[pld_pkg::PL0_W-1:0]};
      end else if (hit_dg1) begin
        rd_data = {14'h0, cur_state[pld_pkg::STATE_W-1:pld_pkg::PL0_W]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin : apb_answer
    if (!presetn) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= rd_data;
      pslverr_r <= rd_err;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign pready  = 1'b1;

endmodule : pld_array_core

/* File: hdl/pld_pkg.sv */
/*
 * Shared constants and types of the programmable AND/OR array core:
 * array sizes, register map, field masks, power-up timing, modes.
 * Assumes a 250 MHz pclk and a 32-bit APB register port.
 */
package pld_pkg;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int N_IN      = 10;
  localparam int N_IO      = 10;
  localparam int N_OUT     = 10;
  localparam int N_BUR     = 8;
  localparam int N_MC      = 18;
  localparam int N_INC     = 20;
  localparam int N_SIG     = 39;
  localparam int N_LIT     = 78;
  localparam int N_PT      = 75;
  localparam int N_OR_IN   = 64;
  localparam int N_ST      = 36;
  localparam int PT_RESET  = 64;
  localparam int PT_OE     = 65;
  localparam int AND_WORDS = 3;
  localparam int OR_WORDS  = 2;
  localparam int SIG_WORDS = 3;
  localparam int AND_TOP_W = 14;
  localparam int STATE_W   = 38;
  localparam int PL0_W     = 20;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_CTRL    = 16'h0000;
  localparam logic [15:0] ADDR_STATUS  = 16'h0004;
  localparam logic [15:0] ADDR_CHKSUM  = 16'h0008;
  localparam logic [15:0] ADDR_PRELD0  = 16'h0010;
  localparam logic [15:0] ADDR_PRELD1  = 16'h0014;
  localparam logic [15:0] ADDR_DIAG0   = 16'h0018;
  localparam logic [15:0] ADDR_DIAG1   = 16'h001C;
  localparam logic [11:0] ROW_SIG      = 12'h002;
  localparam logic [7:0]  PAGE_MC      = 8'h01;
  localparam logic [7:0]  PAGE_INC     = 8'h02;
  localparam logic [3:0]  PAGE_AND     = 4'h1;
  localparam logic [3:0]  PAGE_OR      = 4'h2;

  localparam int CTRL_ERASE  = 0;
  localparam int CTRL_SECURE = 1;
  localparam int CTRL_DIAG   = 2;

  localparam logic [31:0] MASK_FULL    = 32'hFFFF_FFFF;
  localparam logic [31:0] MASK_AND_TOP = 32'h0000_3FFF;
  localparam logic [31:0] MASK_SIG_TOP = 32'h0000_00FF;
  localparam logic [31:0] MASK_MC      = 32'h0000_000F;
  localparam logic [31:0] MASK_INC     = 32'h0000_0003;

  // ---------------------------------------------------------------
  // Power-up reset timing (longest time, rounds down)
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int POR_TIME_NS   = 1000;
  localparam int POR_CYCLES    = POR_TIME_NS / CLK_PERIOD_NS;
  localparam int POR_CW        = 9;

  // ---------------------------------------------------------------
  // Cell modes and carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MC_COMB   = 2'h0,
    MC_DE_REG = 2'h1,
    MC_ST_REG = 2'h2
  } mc_mode_type;

  typedef enum logic [1:0] {
    IN_COMB  = 2'h0,
    IN_LATCH = 2'h1,
    IN_REG   = 2'h2
  } in_mode_type;

  typedef struct packed {
    logic        xor_d;
    logic        xor_e;
    mc_mode_type mode;
  } mc_cfg_type;

  typedef struct packed {
    logic [N_BUR-1:0] bur;
    logic [N_OUT-1:0] out;
    logic [N_IO-1:0]  io;
    logic [N_IN-1:0]  in;
  } cell_state_type;

endpackage : pld_pkg

/* File: hdl/input_cell.sv */
/*
 * One input or I/O input cell: pass-through, latch or register on
 * the input clock, with power-up clear and forced preload.
 * Assumes pin and clock levels already synchronous to pclk.
 */
`timescale 1ns/100ps
module input_cell (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               pin,
  input  wire logic               clk_level,
  input  wire logic               clk_rise,
  input  wire logic               pwrup_clear,
  input  wire logic               load,
  input  wire logic               load_val,
  input  wire pld_pkg::in_mode_type mode,
  output logic                    q
);

  logic q_r;
  logic q_nxt;

  // Pass-through mode still takes one pclk stage so that no
  // combinational loop forms through the pins.
  always_comb begin
    if (pwrup_clear) begin
      q_nxt = 1'b0;
    end else if (load) begin
      q_nxt = load_val;
    end else begin
      case (mode)
        pld_pkg::IN_LATCH: q_nxt = clk_level ? pin : q_r;
        pld_pkg::IN_REG:   q_nxt = clk_rise ? pin : q_r;
        default:           q_nxt = pin;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule : input_cell

/* File: hdl/macrocell.sv */
/*
 * One output or buried macrocell: combinational, clock-enabled
 * register on the output clock, or register clocked by its own
 * enable sum term. Assumes sum terms and clocks sampled on pclk.
 */
`timescale 1ns/100ps
module macrocell #(
  parameter bit HAS_XOR_D = 1'b1
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                d_term,
  input  wire logic                e_term,
  input  wire logic                output_clock_rise,
  input  wire pld_pkg::mc_cfg_type cfg,
  input  wire logic                array_rst,
  input  wire logic                pwrup_clear,
  input  wire logic                load,
  input  wire logic                load_val,
  output logic                     q,
  output logic                     cell_out
);

  logic q_r;
  logic q_nxt;
  logic e_prev_r;
  logic d_eff;
  logic e_eff;
  logic st_rise;

  // Polarity sits ahead of the register so a cleared cell in either
  // registered mode shows high through the inverting pin buffer.
  assign d_eff   = d_term ^ (cfg.xor_d & HAS_XOR_D);
  assign e_eff   = e_term ^ cfg.xor_e;
  assign st_rise = e_eff & ~e_prev_r;

  always_comb begin
    if (pwrup_clear || array_rst) begin
      q_nxt = 1'b0;
    end else if (load) begin
      q_nxt = load_val;
    end else begin
      case (cfg.mode)
        pld_pkg::MC_DE_REG: q_nxt = (output_clock_rise & e_eff) ? d_eff : q_r;
        pld_pkg::MC_ST_REG: q_nxt = st_rise ? d_eff : q_r;
        default:            q_nxt = d_eff;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r      <= 1'b0;
      e_prev_r <= 1'b0;
    end else begin
      q_r      <= q_nxt;
      e_prev_r <= e_eff;
    end
  end

  assign q        = array_rst ? 1'b0 : q_r;
  assign cell_out = (cfg.mode == pld_pkg::MC_DE_REG ||
                     cfg.mode == pld_pkg::MC_ST_REG) ? q : d_eff;

endmodule : macrocell

/* File: verif/board_model.sv */
/* Board pins around the array core.
   Assumes the bench sets pin levels and drive masks. */
`timescale 1ns/100ps
module board_model (
  input  wire logic [9:0] in_val,
  input  wire logic [9:0] in_en,
  input  wire logic [9:0] io_out,
  input  wire logic [9:0] io_oe,
  output logic      [9:0] in_pin,
  output logic      [9:0] in_driven,
  output logic      [9:0] io_in,
  output logic      [9:0] io_driven
);
  // Undriven lines read low here, so only the core's pull-up lifts them
  assign in_pin    = in_val & in_en;
  assign in_driven = in_en;
  assign io_in     = io_out & io_oe;
  assign io_driven = io_oe;
endmodule : board_model

/* File: verif/pld_array_props.sv */
/* Port checker of the array core.
   Bound to pld_array_core; sees its ports only. */
`timescale 1ns/100ps
module pld_array_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [9:0]  io_out,
  input wire logic [9:0]  io_oe
);
  logic       sec_r;
  logic       diag_r;
  logic [8:0] por_r;
  wire        wr_ctl = psel && penable && pwrite && paddr == 16'h0000;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_r  <= 1'h0;
      diag_r <= 1'h0;
      por_r  <= 9'h000;
    end else begin
      if (por_r != 9'h1FF) por_r <= por_r + 9'h001;
      if (wr_ctl) sec_r <= pwdata[1] | (sec_r & ~pwdata[0]);
      if (wr_ctl) diag_r <= pwdata[2];
    end
  end
  sequence rd_at(logic [15:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence rd_and;
    psel && !penable && !pwrite && paddr[15:11] == 5'h02;
  endsequence
  a_sig_read: assert property (
    rd_at(16'h0020) |=> !pslverr) else $error("signature read refused");
  a_and_hidden: assert property (
    sec_r ##0 rd_and |=> prdata == 32'h0 && pslverr)
    else $error("array readable");
  a_sec_flag: assert property (
    rd_at(16'h0004) |=> prdata[0] == $past(sec_r)) else $error("sec flag");
  a_diag_shut: assert property (
    !diag_r ##0 rd_at(16'h0018) |=> prdata == 32'h0 && pslverr)
    else $error("diag");
  a_por_busy: assert property (
    (por_r < 9'h0FA) ##0 rd_at(16'h0004) |=> prdata[2]) else $error("busy");
  a_por_bound: assert property (
    (por_r >= 9'h0FA) ##0 rd_at(16'h0004) |=> !prdata[2]) else $error("late");
  a_pins_high: assert property (
    $rose(presetn) |-> io_out == 10'h3FF && io_oe == 10'h000)
    else $error("pins not high");
  a_erase_oe: assert property (
    wr_ctl && pwdata[0] |=> io_oe == 10'h000) else $error("oe after erase");
endmodule : pld_array_props
bind pld_array_core pld_array_props chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .io_out(io_out), .io_oe(io_oe));

/* File: verif/tb.sv */
/* Self-checking bench of the array core over APB.
   Assumes the bound checker and the board model. */
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ick, ock;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdat, c;
  logic [9:0]  in_val, in_en, in_pin, in_drv, io_in, io_drv, io_out, io_oe;
  logic        rerr;
  int          err_total, checks_done;
  board_model bm_u (.in_val(in_val), .in_en(in_en), .io_out(io_out),
    .io_oe(io_oe), .in_pin(in_pin), .in_driven(in_drv), .io_in(io_in),
    .io_driven(io_drv));
  pld_array_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_pin(in_pin),
    .in_driven(in_drv), .io_in(io_in), .io_driven(io_drv), .io_out(io_out),
    .io_oe(io_oe), .input_clock(ick), .output_clock(ock));
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) begin err_total++; wrap_up(); end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : bus
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    bus(1'h0, a, 32'h0);
    `CHK(rdat, x)
  endtask : rd
  task automatic st;
    repeat (4) @(posedge pclk);
  endtask : st
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    {psel, penable, pwrite, ick, ock, presetn} = 6'h00;
    {paddr, pwdata, in_val, in_en} = {16'h0, 32'h0, 10'h0, 10'h3FF};
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    `CHK(io_out, 10'h3FF)
    `CHK(io_oe, 10'h000)
    rd(16'h0004, 32'h4);
    repeat (250) @(posedge pclk);
    rd(16'h0004, 32'h0);
    for (int i = 0; i < 20; i++) begin
      wr(16'h0200 + 16'(4 * i), 32'h2);
      if (i < 18) wr(16'h0100 + 16'(4 * i), 32'h1);
    end
    wr(16'h0000, 32'h4);
    wr(16'h0010, 32'h000A5C3A);
    wr(16'h0014, 32'h00025A96);
    rd(16'h0018, 32'h000A5C3A);
    rd(16'h001C, 32'h00025A96);
    wr(16'h0020, 32'h11111111);
    bus(1'h0, 16'h0008, 32'h0);
    c = rdat;
    wr(16'h0020, 32'h11111112);
    rd(16'h0008, c + 32'h1);
    wr(16'h1410, 32'h2);
    wr(16'h0000, 32'h2);
    rd(16'h1410, 32'h0);
    `CHK(rerr, 1'h1)
    rd(16'h0018, 32'h0);
    `CHK(rerr, 1'h1)
    rd(16'h0020, 32'h11111112);
    `CHK(rerr, 1'h0)
    wr(16'h0000, 32'h0);
    rd(16'h0004, 32'h1);
    bus(1'h0, 16'h0F00, 32'h0);
    `CHK(rerr, 1'h1)
    wr(16'h0000, 32'h1);
    rd(16'h0004, 32'h0);
    rd(16'h0008, 32'h0);
    wr(16'h1410, 32'h2);
    wr(16'h1410, 32'h1);
    rd(16'h1410, 32'h1);
    in_val <= 10'h001;
    st();
    `CHK(io_oe[0], 1'h1)
    in_val <= 10'h000;
    st();
    `CHK(io_oe[0], 1'h0)
    in_en <= 10'h3FE;
    st();
    `CHK(io_oe[0], 1'h1)
    wr(16'h1008, 32'h2000);
    wr(16'h2000, 32'h1);
    st();
    `CHK(io_out[0], 1'h0)
    ick <= 1'h1;
    st();
    `CHK(io_out[0], 1'h1)
    wr(16'h13F0, 32'h4);
    wr(16'h2004, 32'h80000000);
    in_val <= 10'h002;
    st();
    `CHK(io_out[0], 1'h0)
    wr(16'h0104, 32'h1);
    wr(16'h2014, 32'h80000000);
    wr(16'h2134, 32'h80000000);
    ock <= 1'h1;
    st();
    `CHK(io_out[1], 1'h0)
    in_val <= 10'h000;
    ock <= 1'h0;
    st();
    ock <= 1'h1;
    st();
    `CHK(io_out[1], 1'h0)
    wr(16'h1400, 32'h10);
    in_val <= 10'h004;
    st();
    `CHK(io_out[1], 1'h1)
    rd(16'h1400, 32'h10);
    wr(16'h0108, 32'h2);
    wr(16'h2024, 32'h80000000);
    wr(16'h2140, 32'h1);
    in_val <= 10'h002;
    st();
    `CHK(io_out[2], 1'h1)
    ick <= 1'h0;
    st();
    `CHK(io_out[2], 1'h0)
    // Input cell 0 as a latch: holds while input_clock is low
    wr(16'h0200, 32'h1);
    in_en <= 10'h3FF;
    st();
    `CHK(io_oe[0], 1'h1)
    ick <= 1'h1;
    st();
    `CHK(io_oe[0], 1'h0)
    wrap_up();
  end
endmodule : tb
